//--- verilog/cgcr_defs.svh
// Register offsets, field masks, reset values and timing counts of the clock generator control bank
`ifndef CGCR_DEFS_SVH
`define CGCR_DEFS_SVH

`define CGCR_OFF_MODE       8'h00
`define CGCR_OFF_INDEX      8'h01
`define CGCR_OFF_ASSOC      8'h02
`define CGCR_OFF_OUT_HOLD   8'h03
`define CGCR_OFF_PLL_HOLD   8'h04

`define CGCR_RST_MODE       8'h00
`define CGCR_RST_INDEX      8'h00
`define CGCR_RST_ASSOC      8'h02
`define CGCR_RST_OUT_HOLD   8'h02
`define CGCR_RST_PLL_HOLD   8'h0F

`define CGCR_MASK_MODE      8'h01
`define CGCR_MASK_INDEX     8'h07
`define CGCR_MASK_ASSOC     8'hFF
`define CGCR_MASK_OUT_HOLD  8'h7F
`define CGCR_MASK_PLL_HOLD  8'h8F

`define CGCR_POS_SRC        0
`define CGCR_POS_SHUT_CFG   7

// Arbitrary serial address, not tied to any real part
`define CGCR_DEV_ADDR       7'h6A

`define CGCR_CLK_KHZ        40000
`define CGCR_PWRUP_LOCK_MS  20
`define CGCR_RESUME_LOCK_MS 2
`define CGCR_PWRUP_LOCK_CYC (`CGCR_PWRUP_LOCK_MS * `CGCR_CLK_KHZ)
`define CGCR_RESUME_LOCK_CYC (`CGCR_RESUME_LOCK_MS * `CGCR_CLK_KHZ)
`define CGCR_LOCK_CW        20

`define CGCR_RATE_00        12'hDAC
`define CGCR_RATE_01        12'hABE
`define CGCR_RATE_10        12'h7D0
`define CGCR_RATE_11        12'h4E2

`endif

//--- verilog/cgcr_pkg.sv
// Types shared by the clock generator control bank
package cgcr_pkg;

  typedef enum logic [2:0] {
    CGCR_IDLE     = 3'h0,
    CGCR_ADDR     = 3'h1,
    CGCR_ACK_ADDR = 3'h3,
    CGCR_WR       = 3'h2,
    CGCR_ACK_WR   = 3'h6,
    CGCR_RD       = 3'h7,
    CGCR_ACK_RD   = 3'h5
  } cgcr_link_e;

  typedef enum logic [1:0] {
    CGCR_EDGE_FASTEST = 2'h0,
    CGCR_EDGE_FAST    = 2'h1,
    CGCR_EDGE_SLOW    = 2'h2,
    CGCR_EDGE_SLOWEST = 2'h3
  } cgcr_edge_e;

  typedef struct packed {
    logic [19:0] cnt;
    logic        locked;
  } cgcr_timer_s;

  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       scl_p;
    logic       sda_m;
    logic       sda_s;
    logic       sda_p;
    logic [2:0] sel_m;
    logic [2:0] sel_s;
    logic       sd_m;
    logic       sd_s;
    cgcr_link_e st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic       rw;
    logic       first;
    logic       acked;
    logic [7:0] ptr;
    logic       sda_oe_n;
    logic       mode;
    logic [2:0] idx;
    logic [7:0] assoc;
    logic [6:0] hold_n;
    logic       shut_cfg;
    logic [3:0] pll_hold_n;
    logic [6:0] out_en;
    logic [6:0] out_hiz;
    logic [3:0] pll_run;
    logic       shut;
    logic [2:0] cfg_idx;
    logic [11:0] rate;
    logic       rate_ok;
  } cgcr_state_s;

endpackage

//--- verilog/cgcr_lock_timer.sv
// PLL lock timer: power-up lock and lock after leaving shutdown
`timescale 1ns/100ps
`include "cgcr_defs.svh"
module cgcr_lock_timer #(
  parameter int PWRUP_CYC  = `CGCR_PWRUP_LOCK_CYC,
  parameter int RESUME_CYC = `CGCR_RESUME_LOCK_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pll_down,
  output logic      pll_locked
);
  import cgcr_pkg::*;

  cgcr_timer_s q;
  cgcr_timer_s d;

  always_comb begin
    d = q;
    // R08: resume lock count
    if (pll_down) begin
      d.cnt    = `CGCR_LOCK_CW'(RESUME_CYC - 1);
      d.locked = 1'b0;
    end else if (q.cnt != '0) begin
      d.cnt    = q.cnt - 20'h00001;
      d.locked = 1'b0;
    end else begin
      d.locked = 1'b1;
    end
  end

  // R07: power-up lock count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.cnt    <= `CGCR_LOCK_CW'(PWRUP_CYC - 1);
      q.locked <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign pll_locked = q.locked;
endmodule

//--- verilog/cgcr_top.sv
// Control register bank of a multi-PLL clock generator, reached over a two-wire serial bus
//
// Overview of operation
// R01: Mode bit 0 picks configuration source: 0 pins, 1 software.
// R02: In software mode the three-bit index selects the active configuration.
// R03: Associated output suspends while shutdown_enable_pin is high, using its disable style.
// R04: Unassociated output stays enabled and ignores shutdown_enable_pin; this is the default. Reset value 8'h02 leaves output 1 associated.
// The code still suspends unassociated outputs while the pin is high and the shutdown config bit is set.
// R05: An output whose output_hold_n bit is 0 is suspended, overriding association.
// R06: A PLL whose pll_hold_n bit is 0 is suspended; all four run after reset.
// R07: After power-up, configuration load and PLL lock finish within 20 ms.
// R08: After leaving shutdown, PLL lock is reached within 2 ms.
// R09: Two-bit edge_rate_sel decodes to 3.5, 2.75, 2 or 1.25 V/ns.
// R10: Host should pick 2.75 V/ns or faster for outputs at 100 MHz or more.
// R11: Reserved bits read as zero and ignore writes.
`timescale 1ns/100ps
`include "cgcr_defs.svh"
module cgcr_top #(
  parameter logic [6:0] DEV_ADDR   = `CGCR_DEV_ADDR,
  parameter int         PWRUP_CYC  = `CGCR_PWRUP_LOCK_CYC,
  parameter int         RESUME_CYC = `CGCR_RESUME_LOCK_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_n,
  input  wire logic [2:0]          sel_pin,
  input  wire logic                shutdown_enable_pin,
  input  wire logic [6:0]          output_disable_style,
  input  wire cgcr_pkg::cgcr_edge_e edge_rate_sel,
  output logic [6:0]               clock_output_en,
  output logic [6:0]               clock_output_hiz,
  output logic [3:0]               pll_run,
  output logic                     pll_shutdown,
  output logic                     pll_locked,
  output logic [2:0]               config_index,
  output logic [11:0]              edge_rate_mv_ns,
  output logic                     edge_rate_fast_ok
);
  import cgcr_pkg::*;

  cgcr_state_s q;
  cgcr_state_s d;

  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic [7:0] rd_data;

  // R11: reserved bits read zero
  function automatic logic [7:0] read_reg(input logic [7:0] adr, input cgcr_state_s s);
    logic [7:0] v;
    v = 8'h00;
    case (adr)
      `CGCR_OFF_MODE:     v = {7'h00, s.mode};
      `CGCR_OFF_INDEX:    v = {5'h00, s.idx};
      `CGCR_OFF_ASSOC:    v = s.assoc;
      `CGCR_OFF_OUT_HOLD: v = {1'b0, s.hold_n};
      `CGCR_OFF_PLL_HOLD: v = {s.shut_cfg, 3'h0, s.pll_hold_n};
      default:            v = 8'h00;
    endcase
    return v;
  endfunction

  // R09: edge rate decode in mV/ns
  function automatic logic [11:0] edge_rate(input cgcr_edge_e e);
    logic [11:0] r;
    r = `CGCR_RATE_00;
    unique case (e)
      CGCR_EDGE_FASTEST: r = `CGCR_RATE_00;
      CGCR_EDGE_FAST:    r = `CGCR_RATE_01;
      CGCR_EDGE_SLOW:    r = `CGCR_RATE_10;
      CGCR_EDGE_SLOWEST: r = `CGCR_RATE_11;
    endcase
    return r;
  endfunction

  assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_c  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  assign rise_c  = q.scl_s & ~q.scl_p;
  assign fall_c  = ~q.scl_s & q.scl_p;
  assign rd_data = read_reg(q.ptr, q);

  always_comb begin
    logic       pin_oe;
    logic [7:0] wv;
    pin_oe = 1'b0;
    wv     = 8'h00;
    d = q;
    d.scl_m = scl_i;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_i;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.sel_m = sel_pin;
    d.sel_s = q.sel_m;
    d.sd_m  = shutdown_enable_pin;
    d.sd_s  = q.sd_m;

    if (start_c) begin
      d.st       = CGCR_ADDR;
      d.cnt      = 4'h0;
      d.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      d.st       = CGCR_IDLE;
      d.sda_oe_n = 1'b1;
    end else if (rise_c) begin
      unique case (q.st)
        CGCR_ADDR, CGCR_WR: begin
          if (q.cnt != 4'h8) begin
            d.shreg = {q.shreg[6:0], q.sda_s};
            d.cnt = q.cnt + 4'h1;
          end
        end
        CGCR_RD: begin
          if (q.cnt != 4'h8) begin
            d.shreg = {q.shreg[6:0], 1'b0};
            d.cnt = q.cnt + 4'h1;
          end
        end
        CGCR_ACK_RD: d.acked = ~q.sda_s;
        default: ;
      endcase
    end else if (fall_c) begin
      unique case (q.st)
        CGCR_ADDR: begin
          if (q.cnt == 4'h8) begin
            if (q.shreg[7:1] == DEV_ADDR) begin
              d.st       = CGCR_ACK_ADDR;
              d.rw       = q.shreg[0];
              d.sda_oe_n = 1'b0;
            end else begin
              d.st = CGCR_IDLE;
            end
          end
        end
        CGCR_ACK_ADDR: begin
          d.cnt = 4'h0;
          if (q.rw) begin
            d.st       = CGCR_RD;
            d.shreg    = rd_data;
            d.sda_oe_n = rd_data[7];
            d.ptr      = q.ptr + 8'h01;
          end else begin
            d.st       = CGCR_WR;
            d.first    = 1'b1;
            d.sda_oe_n = 1'b1;
          end
        end
        CGCR_WR: begin
          if (q.cnt == 4'h8) begin
            d.st       = CGCR_ACK_WR;
            d.sda_oe_n = 1'b0;
            if (q.first) begin
              d.ptr   = q.shreg;
              d.first = 1'b0;
            end else begin
              d.ptr = q.ptr + 8'h01;
              // R11: reserved bits ignore writes
              case (q.ptr)
                `CGCR_OFF_MODE: begin
                  wv     = q.shreg & `CGCR_MASK_MODE;
                  d.mode = wv[`CGCR_POS_SRC];
                end
                `CGCR_OFF_INDEX: begin
                  wv    = q.shreg & `CGCR_MASK_INDEX;
                  d.idx = wv[2:0];
                end
                `CGCR_OFF_ASSOC: d.assoc = q.shreg & `CGCR_MASK_ASSOC;
                `CGCR_OFF_OUT_HOLD: begin
                  wv       = q.shreg & `CGCR_MASK_OUT_HOLD;
                  d.hold_n = wv[6:0];
                end
                `CGCR_OFF_PLL_HOLD: begin
                  wv           = q.shreg & `CGCR_MASK_PLL_HOLD;
                  d.shut_cfg   = wv[`CGCR_POS_SHUT_CFG];
                  d.pll_hold_n = wv[3:0];
                end
                default: ;
              endcase
            end
          end
        end
        CGCR_ACK_WR: begin
          d.st       = CGCR_WR;
          d.cnt      = 4'h0;
          d.sda_oe_n = 1'b1;
        end
        CGCR_RD: begin
          d.sda_oe_n = (q.cnt == 4'h8) ? 1'b1 : q.shreg[7];
          if (q.cnt == 4'h8) begin
            d.st = CGCR_ACK_RD;
          end
        end
        CGCR_ACK_RD: begin
          if (q.acked) begin
            d.st       = CGCR_RD;
            d.cnt      = 4'h0;
            d.shreg    = rd_data;
            d.sda_oe_n = rd_data[7];
            d.ptr      = q.ptr + 8'h01;
          end else begin
            d.st       = CGCR_IDLE;
            d.sda_oe_n = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // Pin acts as shutdown when the shutdown config bit is set, else as output enable
    d.shut = q.sd_s & q.shut_cfg;
    pin_oe = q.sd_s & ~q.shut_cfg;
    for (int i = 0; i < 7; i++) begin
      // R05: hold overrides association
      if (!q.hold_n[i] || q.shut) begin
        d.out_en[i]  = 1'b0;
        d.out_hiz[i] = output_disable_style[i];
      // R03: pin suspends associated output
      end else if (q.assoc[i] && pin_oe) begin
        d.out_en[i]  = 1'b0;
        d.out_hiz[i] = output_disable_style[i];
      // R04: unassociated output stays on
      end else begin
        d.out_en[i]  = 1'b1;
        d.out_hiz[i] = 1'b0;
      end
    end
    // R06: PLL suspend, active low
    d.pll_run = q.pll_hold_n & {4{~q.shut}};
    // R01: configuration source select
    // R02: software index replaces select pins
    d.cfg_idx = q.mode ? q.idx : q.sel_s;
    // R09: edge rate output
    d.rate    = edge_rate(edge_rate_sel);
    d.rate_ok = (edge_rate_sel == CGCR_EDGE_FASTEST) || (edge_rate_sel == CGCR_EDGE_FAST);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q            <= '0;
      q.scl_m      <= 1'b1;
      q.scl_s      <= 1'b1;
      q.scl_p      <= 1'b1;
      q.sda_m      <= 1'b1;
      q.sda_s      <= 1'b1;
      q.sda_p      <= 1'b1;
      q.st         <= CGCR_IDLE;
      q.sda_oe_n   <= 1'b1;
      q.mode       <= 1'(`CGCR_RST_MODE & `CGCR_MASK_MODE);
      q.idx        <= 3'(`CGCR_RST_INDEX);
      q.assoc      <= `CGCR_RST_ASSOC;
      q.hold_n     <= 7'(`CGCR_RST_OUT_HOLD);
      q.shut_cfg   <= 1'((`CGCR_RST_PLL_HOLD) >> `CGCR_POS_SHUT_CFG);
      q.pll_hold_n <= 4'(`CGCR_RST_PLL_HOLD);
      q.rate       <= `CGCR_RATE_00;
    end else begin
      q <= d;
    end
  end

  // R07: lock after power-up
  // R08: lock after shutdown
  cgcr_lock_timer #(
    .PWRUP_CYC  (PWRUP_CYC),
    .RESUME_CYC (RESUME_CYC)
  ) u_lock (
    .clk        (clk),
    .rst        (rst),
    .pll_down   (q.shut),
    .pll_locked (pll_locked)
  );

  assign sda_o             = 1'b0;
  assign sda_oe_n          = q.sda_oe_n;
  assign clock_output_en   = q.out_en;
  assign clock_output_hiz  = q.out_hiz;
  assign pll_run           = q.pll_run;
  assign pll_shutdown      = q.shut;
  assign config_index      = q.cfg_idx;
  assign edge_rate_mv_ns   = q.rate;
  assign edge_rate_fast_ok = q.rate_ok;
endmodule

//--- tb/cgcr_checker.sv
// Port assertions for the clock generator control bank
`timescale 1ns/100ps
module cgcr_checker #(
  parameter int PWRUP_CYC  = 50,
  parameter int RESUME_CYC = 20
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 shutdown_enable_pin,
  input wire cgcr_pkg::cgcr_edge_e edge_rate_sel,
  input wire logic [6:0]           clock_output_en,
  input wire logic [6:0]           clock_output_hiz,
  input wire logic [3:0]           pll_run,
  input wire logic                 pll_shutdown,
  input wire logic                 pll_locked,
  input wire logic [11:0]          edge_rate_mv_ns,
  input wire logic                 edge_rate_fast_ok
);
  import cgcr_pkg::*;
  localparam int RMAX = RESUME_CYC + 4;
  logic [20:0] wait_q;
  logic [20:0] wait_d;
  // Cycles spent waiting for lock outside shutdown
  always_comb wait_d = (pll_locked || pll_shutdown) ? 21'h0 : wait_q + 21'h1;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      wait_q <= 21'h0;
    else
      wait_q <= wait_d;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_pin_quiet;
    !shutdown_enable_pin [*5];
  endsequence
  sequence s_relock;
    ##[1:RMAX] pll_locked;
  endsequence
  AST_RATE: assert property (!$past(rst) && $stable(edge_rate_sel) |=>
    edge_rate_mv_ns == 12'(3500 - 750 * $past(edge_rate_sel)))
    else $error("edge rate value wrong");
  AST_FAST: assert property (!$past(rst) && $stable(edge_rate_sel) |=>
    edge_rate_fast_ok == ($past(edge_rate_sel) < 2))
    else $error("fast edge flag wrong");
  AST_SHUT: assert property (pll_shutdown [*2] |-> pll_run == 4'h0 && clock_output_en == 7'h0)
    else $error("outputs or PLLs run in shutdown");
  AST_SHUT_LOCK: assert property (pll_shutdown [*2] |-> !pll_locked)
    else $error("lock held in shutdown");
  AST_RESUME: assert property ($fell(pll_shutdown) |-> s_relock)
    else $error("lock late after shutdown");
  AST_PWRUP: assert property (wait_q <= 21'(PWRUP_CYC + 4))
    else $error("power-up lock late");
  AST_HIZ: assert property ((clock_output_hiz & clock_output_en) == 7'h0)
    else $error("running output marked hi-z");
  AST_PIN_LOW: assert property (s_pin_quiet |-> !pll_shutdown)
    else $error("shutdown without pin");
endmodule
bind cgcr_top cgcr_checker #(.PWRUP_CYC(PWRUP_CYC), .RESUME_CYC(RESUME_CYC)) u_chk (
  .clk, .rst, .shutdown_enable_pin, .edge_rate_sel, .clock_output_en, .clock_output_hiz,
  .pll_run, .pll_shutdown, .pll_locked, .edge_rate_mv_ns, .edge_rate_fast_ok);

//--- tb/cgcr_host.sv
// Serial bus host model that configures the control bank
`timescale 1ns/100ps
`include "cgcr_defs.svh"
module cgcr_host (
  input wire logic clk,
  input wire logic sda_i,
  output logic     scl,
  output logic     sda_m
);
  logic [8:0] shreg;
  logic [7:0] got;
  logic       ack;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hp();
    repeat (8) @(posedge clk);
  endtask
  // Start or repeated start: data falls while clock is high
  task automatic start();
    sda_m <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_m <= 1'b0;
    hp();
    scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_m <= 1'b1;
    hp();
  endtask
  // Eight bits MSB first, then the line is released for the ninth
  task automatic xfer(input logic [7:0] d);
    for (int i = 8; i >= 0; i--) begin
      sda_m <= (i == 0) ? 1'b1 : d[i - 1];
      hp();
      scl <= 1'b1;
      hp();
      shreg = {shreg[7:0], sda_i};
      scl <= 1'b0;
      repeat (2) @(posedge clk);
    end
    got = shreg[8:1];
    ack = ~shreg[0];
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    start();
    xfer({`CGCR_DEV_ADDR, 1'b0});
    xfer(p);
    xfer(v);
    stop();
  endtask
  task automatic rd(input logic [7:0] p);
    start();
    xfer({`CGCR_DEV_ADDR, 1'b0});
    xfer(p);
    start();
    xfer({`CGCR_DEV_ADDR, 1'b1});
    xfer(8'hFF);
    stop();
  endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the clock generator control bank
`timescale 1ns/100ps
`include "cgcr_defs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; $display("FAIL %0t got %0h exp %0h", $time, a, e); end end
module tb_top;
  import cgcr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        scl_i;
  logic        sda_m;
  logic        sda_o;
  logic        sda_oe_n;
  logic        shutdown_enable_pin;
  logic [2:0]  sel_pin;
  logic [2:0]  config_index;
  logic [6:0]  output_disable_style;
  logic [6:0]  clock_output_en;
  logic [6:0]  clock_output_hiz;
  logic [3:0]  pll_run;
  logic        pll_shutdown;
  logic        pll_locked;
  logic [11:0] edge_rate_mv_ns;
  logic        edge_rate_fast_ok;
  cgcr_edge_e  edge_rate_sel;
  logic [7:0]  m [6] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h0F, 8'h00};
  logic [7:0]  mask [6] = '{8'h01, 8'h07, 8'hFF, 8'h7F, 8'h8F, 8'h00};
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0;
  // Open-drain line with pull-up
  wire         sda_i = sda_m & (sda_oe_n | sda_o);
  cgcr_top #(.PWRUP_CYC(50), .RESUME_CYC(20)) dut (
    .clk, .rst, .scl_i, .sda_i, .sda_o, .sda_oe_n, .sel_pin, .shutdown_enable_pin, .output_disable_style,
    .edge_rate_sel, .clock_output_en, .clock_output_hiz, .pll_run, .pll_shutdown, .pll_locked, .config_index,
    .edge_rate_mv_ns, .edge_rate_fast_ok);
  cgcr_host host (.clk, .sda_i, .scl(scl_i), .sda_m);
  always #12.5 clk = ~clk;
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  // Outputs predicted from the register model and pins
  task automatic check_out();
    logic       s;
    logic [6:0] dis;
    repeat (8) @(posedge clk);
    s = shutdown_enable_pin & m[4][7];
    dis = ~m[3][6:0] | {7{s}} | (m[2][6:0] & {7{shutdown_enable_pin & ~m[4][7]}});
    `CHK(clock_output_en, ~dis)
    `CHK(clock_output_hiz, dis & output_disable_style)
    `CHK(pll_run, s ? 4'h0 : m[4][3:0])
    `CHK(pll_shutdown, s)
    `CHK(config_index, m[0][0] ? m[1][2:0] : sel_pin)
    `CHK(edge_rate_mv_ns, 12'(3500 - 750 * edge_rate_sel))
    `CHK(edge_rate_fast_ok, edge_rate_sel < 2)
  endtask
  initial begin
    void'($urandom(9515));
    shutdown_enable_pin = 1'b0;
    sel_pin = 3'h5;
    output_disable_style = 7'h55;
    edge_rate_sel = CGCR_EDGE_SLOW;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(pll_locked, 1'b0)
    check_out();
    for (int a = 0; a < 6; a++) begin
      host.rd(8'(a));
      `CHK(host.got, m[a])
    end
    `CHK(pll_locked, 1'b1)
    host.wr(8'h01, 8'hFA);
    m[1] = 8'h02;
    host.wr(8'h00, 8'hFF);
    m[0] = 8'h01;
    host.wr(8'h04, 8'hFF);
    m[4] = 8'h8F;
    check_out();
    shutdown_enable_pin <= 1'b1;
    check_out();
    `CHK(pll_locked, 1'b0)
    shutdown_enable_pin <= 1'b0;
    repeat (26) @(posedge clk);
    `CHK(pll_locked, 1'b1)
    for (int n = 0; n < 16; n++) begin
      logic [7:0] p;
      logic [7:0] v;
      p = 8'($urandom_range(5));
      v = 8'($urandom);
      shutdown_enable_pin <= 1'($urandom);
      sel_pin <= 3'($urandom);
      output_disable_style <= 7'($urandom);
      edge_rate_sel <= cgcr_edge_e'($urandom_range(3));
      host.wr(p, v);
      `CHK(host.ack, 1'b1)
      if (p < 5)
        m[p] = v & mask[p];
      host.rd(p);
      `CHK(host.got, m[p])
      check_out();
    end
    give_verdict();
  end
endmodule
